// file: bench/bsc_fe_model.sv
/* bsc_fe_model: converter front end facing the correction block.
   Assumes the bench sets reading and latency before each start. */
`timescale 1ns/1ps

module bsc_fe_model (
    // clock and start request
    input wire logic clk,
    input wire logic meas_start,
    // reading and latency chosen by the bench
    input wire logic [17:0] raw_next,
    input wire logic [3:0] lat,
    // reading handed back
    output logic raw_valid,
    output logic [17:0] raw_data
);
    int cnt = -1;

    // quiet lines at time zero
    initial begin
        raw_valid = 1'b0;
        raw_data = 18'h0_0000;
    end

    // signed raw reading
    // data toggles outside the valid cycle so a stale value never matches
    always @(posedge clk) begin
        raw_valid <= 1'b0;
        raw_data <= ~raw_data;
        if (meas_start) cnt = lat;
        else if (cnt > 0) cnt = cnt - 1;
        if (cnt == 0) begin
            raw_valid <= 1'b1;
            raw_data <= raw_next;
            cnt = -1;
        end
    end
endmodule : bsc_fe_model

// file: bench/bsc_top_props.sv
/* bsc_top_props: port timing checks of the correction block.
   Assumes a bind onto bsc_top, one clock, synchronous reset. */
`timescale 1ns/1ps

module bsc_top_props
    import bsc_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // command port
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_CODE,
    input wire logic [15:0] CMD_DATA,
    input wire logic CMD_READY,
    // front end
    input wire logic MEAS_START,
    input wire logic MEAS_TEMP,
    input wire logic [15:0] MEAS_CONFIG,
    input wire logic RAW_VALID,
    input wire logic [17:0] RAW_DATA,
    // results
    input wire logic RESULT_VALID,
    input wire logic [17:0] RESULT_DATA,
    input wire logic [7:0] RESULT_STATUS,
    input wire logic PROG_BUSY
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // command accepted at this edge
    wire take = CMD_VALID && CMD_READY;
    logic wait_q;
    logic corr_q;

    // owner of the pending conversion
    always_ff @(posedge CLK) begin
        if (RST) begin
            wait_q <= 1'b0;
            corr_q <= 1'b0;
        end else begin
            if (take) corr_q <= (CMD_CODE == BSC_CMD_CORR);
            if (MEAS_START) wait_q <= 1'b1;
            else if (RAW_VALID) wait_q <= 1'b0;
        end
    end

    a_host_bridge: assert property (
        take && CMD_CODE == BSC_CMD_BR_HOST |=> MEAS_START && !MEAS_TEMP
        && MEAS_CONFIG == $past(CMD_DATA)) else $error("host bridge setup");
    a_host_temp: assert property (
        take && CMD_CODE == BSC_CMD_T_HOST |=> MEAS_START && MEAS_TEMP
        && MEAS_CONFIG == $past(CMD_DATA)) else $error("host temp setup");
    a_stored_bridge: assert property (
        take && CMD_CODE == BSC_CMD_BR_NV |=> !MEAS_START ##1 MEAS_START && !MEAS_TEMP)
        else $error("stored bridge start");
    a_factory_temp: assert property (
        take && CMD_CODE == BSC_CMD_T_NV |=> !MEAS_START ##1 MEAS_START && MEAS_TEMP)
        else $error("factory temp start");
    a_read_lat: assert property (
        take && CMD_CODE < 8'h20 |=> !RESULT_VALID ##1 RESULT_VALID)
        else $error("read latency");
    a_raw_echo: assert property (
        RAW_VALID && wait_q && !corr_q |=> RESULT_VALID
        && RESULT_DATA == $past(RAW_DATA)) else $error("raw echo");
    a_corr_lat: assert property (
        RAW_VALID && wait_q && corr_q |=> !RESULT_VALID [*8] ##20 RESULT_VALID)
        else $error("corrected latency");
    a_corr_range: assert property (
        RESULT_VALID && corr_q |-> RESULT_DATA[17:16] == 2'b00
        && RESULT_STATUS[7:1] == 7'h00) else $error("corrected range");
    a_prog_time: assert property (
        take && CMD_CODE == BSC_CMD_PROG |=> PROG_BUSY [*8] ##24 PROG_BUSY ##1 !PROG_BUSY)
        else $error("program time");
    a_busy_block: assert property (PROG_BUSY |-> !CMD_READY)
        else $error("ready while programming");
    a_status_clear: assert property (take |=> !RESULT_STATUS[0])
        else $error("status not cleared");
endmodule : bsc_top_props

// file: bench/bsc_top_tb_top.sv
/* bsc_top_tb_top: self-checking bench with an integer correction model.
   Assumes the front end model answers every start pulse. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_count++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end

module bsc_top_tb_top
    import bsc_pkg::*;
;
    logic CLK, RST, CMD_VALID, CMD_READY, MEAS_START, MEAS_TEMP, RAW_VALID;
    logic RESULT_VALID, PROG_BUSY, sf;
    logic [7:0] CMD_CODE, RESULT_STATUS, rs;
    logic [15:0] CMD_DATA, MEAS_CONFIG;
    logic [17:0] RAW_DATA, RESULT_DATA, raw_nx, rd;
    logic [3:0] lat;
    logic [17:0] sh [32];
    logic [17:0] nv [32];
    int err_count, cmp_count;

    bsc_top bsc_top_i (.CLK, .RST, .CMD_VALID, .CMD_CODE, .CMD_DATA, .CMD_READY,
        .MEAS_START, .MEAS_TEMP, .MEAS_CONFIG, .RAW_VALID, .RAW_DATA,
        .RESULT_VALID, .RESULT_DATA, .RESULT_STATUS, .PROG_BUSY);
    bsc_fe_model bsc_fe_model_i (.clk(CLK), .meas_start(MEAS_START), .raw_next(raw_nx),
        .lat(lat), .raw_valid(RAW_VALID), .raw_data(RAW_DATA));

    // 125 MHz clock
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    // reference arithmetic; sf gathers every clamp of one calculation
    function automatic longint st(longint v, longint lo, longint hi);
        if (v < lo || v > hi) sf = 1'b1;
        return (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction : st
    function automatic longint s18(longint v);
        return st(v, -131072, 131071);
    endfunction : s18
    function automatic longint ml(longint a, longint b);
        return s18((a * b) >>> 15);
    endfunction : ml
    function automatic longint sx(int a);
        return longint'($signed(nv[a]));
    endfunction : sx
    function automatic int rv(int m);
        return int'($urandom_range(0, 2 * m)) - m;
    endfunction : rv
    function automatic longint corr(longint t, longint br, bit s);
        longint dt, k1, k2, z, r;
        sf = 1'b0;
        dt = s18(t - sx(9));
        k1 = s18(32768 + ml(dt, s18(ml(sx(6), dt) + sx(4))));
        k2 = s18(sx(2) + s18(br + ml(dt, s18(ml(sx(7), dt) + sx(5)))));
        z = ml(sx(3), ml(k1, k2));
        // parabolic form lifts and clamps here, the S-shaped form only at the end
        if (!s) z = st(z + 32768, 0, 131071);
        r = s18(ml(sx(8), (s && z < 0) ? -z : z) + 32768);
        return s ? st(ml(z, r) + 32768, 0, 65535) : st((z * r) >>> 15, 0, 65535);
    endfunction : corr

    // one command, held until taken
    task automatic cmd(input logic [7:0] c, input logic [15:0] d);
        @(posedge CLK) #1;
        CMD_VALID = 1'b1;
        CMD_CODE = c;
        CMD_DATA = d;
        while (CMD_READY !== 1'b1) @(posedge CLK) #1;
        @(posedge CLK) #1;
        CMD_VALID = 1'b0;
    endtask : cmd
    // bounded wait for a result pulse
    task automatic res();
        int n;
        n = 0;
        while (RESULT_VALID !== 1'b1 && n < 200) begin
            @(posedge CLK) #1;
            n++;
        end
        if (n == 200) err_count++;
        rd = RESULT_DATA;
        rs = RESULT_STATUS;
    endtask : res
    // extension only when the upper bits are set, so its clearing is exercised
    task automatic wr(input logic [4:0] a, input logic [17:0] v);
        if (v[17:16] != 2'b00) cmd(BSC_CMD_EXT, {14'h0, v[17:16]});
        cmd(BSC_CMD_WR_BASE + 8'(a), v[15:0]);
        sh[a] = v;
    endtask : wr
    task automatic rdw(input logic [4:0] a);
        cmd(8'(a), 16'h0000);
        res();
        `CHK("shadow read", sh[a], rd)
    endtask : rdw
    task automatic meas(input logic [7:0] c, input logic [15:0] d, input logic [17:0] raw);
        raw_nx = raw;
        lat = 4'($urandom_range(1, 9));
        cmd(c, d);
        res();
    endtask : meas
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim

    // watchdog
    initial begin
        #160000;
        err_count++;
        end_sim();
    end

    // main sequence
    initial begin
        int t, b, m;
        {CMD_VALID, CMD_CODE, CMD_DATA, raw_nx, sf} = '0;
        RST = 1'b1;
        lat = 4'h1;
        err_count = 0;
        cmp_count = 0;
        void'($urandom(32'h12ee322b));
        repeat (6) @(posedge CLK);
        #1 RST = 1'b0;
        wr(BSC_ADDR_ID_LOW, 18'($urandom_range(0, 16'hFFFF)));
        wr(BSC_ADDR_ID_HIGH, 18'($urandom_range(0, 16'hFFFF)));
        rdw(BSC_ADDR_ID_LOW);
        rdw(BSC_ADDR_ID_HIGH);
        // nine pairs, temperature and bridge each under its own fixed host setup
        for (int i = 0; i < 9; i++) begin
            t = rv(131071);
            b = rv(131071);
            meas(BSC_CMD_T_HOST, 16'h5A5A, 18'(t));
            `CHK("temp raw", {1'b1, 16'h5A5A, 18'(t)}, {MEAS_TEMP, MEAS_CONFIG, rd})
            meas(BSC_CMD_BR_HOST, 16'hC3A5, 18'(b));
            `CHK("bridge raw", {1'b0, 16'hC3A5, 18'(b)}, {MEAS_TEMP, MEAS_CONFIG, rd})
        end
        // small coefficients first, then full range to force clamps
        for (int i = 0; i < 6; i++) begin
            m = (i < 3) ? 4095 : 131071;
            wr(5'h02, 18'(rv(m)));
            wr(5'h03, 18'((i < 3) ? 32768 + rv(m) : rv(m)));
            for (int k = 4; k < 9; k++) wr(5'(k), 18'(rv(m)));
            wr(5'h09, 18'($urandom_range(0, 69630) - 4095));
            // even passes parabolic, odd passes S-shaped
            wr(5'h0A, 18'(i % 2));
            wr(BSC_ADDR_BR_SETUP, 18'($urandom_range(0, 16'hFFFF)));
            wr(BSC_ADDR_T_SETUP, 18'($urandom_range(0, 16'hFFFF)));
            cmd(BSC_CMD_PROG, 16'h0000);
            t = 0;
            while (PROG_BUSY === 1'b1 && t < 100) begin
                @(posedge CLK) #1;
                t++;
            end
            `CHK("program cycles", 32, t)
            nv = sh;
            // shadow changes alone must not reach the measurement
            wr(BSC_ADDR_BR_SETUP, ~nv[BSC_ADDR_BR_SETUP] & 18'h0_FFFF);
            t = rv(m);
            b = rv(m);
            meas(BSC_CMD_T_NV, 16'h0000, 18'(t));
            `CHK("factory cfg", {1'b1, nv[24][15:0], 18'(t)}, {MEAS_TEMP, MEAS_CONFIG, rd})
            `CHK("raw status", 8'h00, rs)
            meas(BSC_CMD_BR_NV, 16'h0000, 18'(b));
            `CHK("stored cfg", {1'b0, nv[16][15:0], 18'(b)}, {MEAS_TEMP, MEAS_CONFIG, rd})
            rdw(BSC_ADDR_BR_SETUP);
            meas(BSC_CMD_CORR, 16'h0000, 18'(b));
            `CHK("corrected", corr(t, b, i % 2 == 1), rd)
            `CHK("status", {7'h00, sf}, rs)
        end
        end_sim();
    end
endmodule : bsc_top_tb_top

bind bsc_top bsc_top_props bsc_top_props_i (.CLK, .RST, .CMD_VALID, .CMD_CODE, .CMD_DATA,
    .CMD_READY, .MEAS_START, .MEAS_TEMP, .MEAS_CONFIG, .RAW_VALID, .RAW_DATA,
    .RESULT_VALID, .RESULT_DATA, .RESULT_STATUS, .PROG_BUSY);

// file: design/bsc_coef_store.sv
/*
 * bsc_coef_store: volatile shadow copy and non-volatile store of the
 * calibration words, with a copy engine that programs the whole shadow
 * into the non-volatile array, and one registered read port.
 * Assumes the caller never writes the shadow while a copy is running.
 */
`timescale 1ns/1ps

module bsc_coef_store
    import bsc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // shadow write port
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [17:0] wr_data,
    // programming
    input wire logic prog_start,
    output logic prog_busy,
    // read port, data one cycle after the address
    input wire logic rd_nv,
    input wire logic [4:0] rd_addr,
    output logic [17:0] rd_data
);

    logic [17:0] shadow_mem [0:BSC_DEPTH-1];
    logic [17:0] nv_mem [0:BSC_DEPTH-1];
    logic [4:0] copy_q;
    logic busy_q;

    assign prog_busy = busy_q;

    always_ff @(posedge clk) begin
        if (wr_en) begin
            shadow_mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (busy_q) begin
            nv_mem[copy_q] <= shadow_mem[copy_q];
        end
    end

    // copy engine walks every address once, one word per cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q <= 1'b0;
            copy_q <= '0;
        end else if (!busy_q) begin
            busy_q <= prog_start;
            copy_q <= '0;
        end else begin
            copy_q <= copy_q + 5'd1;
            if (copy_q == BSC_ADDR_LAST) begin
                busy_q <= 1'b0;
            end
        end
    end

    // registered read keeps the long datapath off the array outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= rd_nv ? nv_mem[rd_addr] : shadow_mem[rd_addr];
        end
    end

endmodule : bsc_coef_store

// file: design/bsc_pkg.sv
/*
 * bsc_pkg: shared constants for the bridge signal correction block:
 * command codes, store addresses, coefficient slots, scratch slots,
 * saturation bounds and sequencing counts.
 * Assumes one 125 MHz clock domain; nothing here is timing dependent.
 */
package bsc_pkg;

    // command codes seen on the command port
    localparam logic [7:0] BSC_CMD_WR_BASE = 8'h40;
    localparam logic [7:0] BSC_CMD_RD_BASE = 8'h00;
    localparam logic [7:0] BSC_CMD_BR_NV = 8'hA2;
    localparam logic [7:0] BSC_CMD_BR_HOST = 8'hA3;
    localparam logic [7:0] BSC_CMD_T_NV = 8'hA6;
    localparam logic [7:0] BSC_CMD_T_HOST = 8'hA7;
    localparam logic [7:0] BSC_CMD_CORR = 8'hAA;
    localparam logic [7:0] BSC_CMD_EXT = 8'h3F;
    localparam logic [7:0] BSC_CMD_PROG = 8'hC3;

    // store geometry and addresses
    localparam int BSC_AW = 5;
    localparam int BSC_DEPTH = 32;
    localparam logic [4:0] BSC_ADDR_ID_LOW = 5'h00;
    localparam logic [4:0] BSC_ADDR_ID_HIGH = 5'h01;
    localparam logic [4:0] BSC_ADDR_COEF_BASE = 5'h02;
    localparam logic [4:0] BSC_ADDR_BR_SETUP = 5'h10;
    localparam logic [4:0] BSC_ADDR_T_SETUP = 5'h18;
    localparam logic [4:0] BSC_ADDR_LAST = 5'h1F;

    // coefficient slots, fetched in this order from the coefficient base
    localparam int BSC_C_OFFSET = 0;
    localparam int BSC_C_GAIN = 1;
    localparam int BSC_C_TCG = 2;
    localparam int BSC_C_TCO = 3;
    localparam int BSC_C_GAIN_DRIFT_QUADRATIC_COEF = 4;
    localparam int BSC_C_OFFSET_DRIFT_QUADRATIC_COEF = 5;
    localparam int BSC_C_LIN = 6;
    localparam int BSC_C_TREF = 7;
    localparam int BSC_C_SHAPE = 8;
    localparam int BSC_NCOEF = 9;
    localparam int BSC_SHAPE_BIT = 0;

    // scratch slots of the sequential datapath
    localparam logic [2:0] BSC_W_DT = 3'd0;
    localparam logic [2:0] BSC_W_TA = 3'd1;
    localparam logic [2:0] BSC_W_TB = 3'd2;
    localparam logic [2:0] BSC_W_K1 = 3'd3;
    localparam logic [2:0] BSC_W_K2 = 3'd4;
    localparam logic [2:0] BSC_W_P = 3'd5;
    localparam logic [2:0] BSC_W_Z = 3'd6;
    localparam logic [2:0] BSC_W_Q = 3'd7;

    // sequencing counts
    localparam logic [4:0] BSC_LAST_FETCH = 5'd9;
    localparam logic [4:0] BSC_LAST_STEP = 5'd16;
    localparam int BSC_FRAC = 15;

    // fixed-point constants and bounds
    localparam logic signed [19:0] BSC_ONE = 20'sh0_8000;
    localparam logic signed [19:0] BSC_NIL = 20'sh0_0000;
    localparam logic signed [39:0] BSC_S18_MAX = 40'sh00_0001_FFFF;
    localparam logic signed [39:0] BSC_S18_MIN = -40'sh00_0002_0000;
    localparam logic signed [39:0] BSC_U16_MAX = 40'sh00_0000_FFFF;
    localparam logic signed [39:0] BSC_ZERO = 40'sh00_0000_0000;
    localparam int BSC_SAT_BIT = 0;

endpackage : bsc_pkg

// file: design/bsc_top.sv
/*
 * bsc_top: calibration command handling and the fixed-point bridge
 * correction datapath. Commands arrive already deframed as code plus
 * data word; raw readings come from the converter front end.
 * Assumes command port and front end run on CLK; no synchronisers.
 */
`timescale 1ns/1ps

module bsc_top
    import bsc_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // command port
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_CODE,
    input wire logic [15:0] CMD_DATA,
    output logic CMD_READY,
    // converter front end
    output logic MEAS_START,
    output logic MEAS_TEMP,
    output logic [15:0] MEAS_CONFIG,
    input wire logic RAW_VALID,
    input wire logic [17:0] RAW_DATA,
    // results
    output logic RESULT_VALID,
    output logic [17:0] RESULT_DATA,
    output logic [7:0] RESULT_STATUS,
    // programming
    output logic PROG_BUSY
);

    typedef enum logic [2:0] {
        ST_IDLE, ST_CFG, ST_READ, ST_LAUNCH, ST_WAIT, ST_FETCH, ST_CALC, ST_DONE
    } bsc_state_t;

    bsc_state_t state_q, state_d;
    logic [4:0] step_q, step_d;
    logic [15:0] cfg_q;
    logic temp_q, corr_q, sat_q;
    logic [1:0] ext_q;
    logic [17:0] traw_q, braw_q, result_q;
    logic [17:0] c_q [0:BSC_NCOEF-1];
    logic [17:0] w_q [0:7];
    logic prog_busy;
    logic [17:0] rd_data;

    function automatic logic signed [19:0] x20(input logic [17:0] v);
        return {{2{v[17]}}, v};
    endfunction : x20

    // command decode
    wire cmd_take = CMD_VALID && (state_q == ST_IDLE) && !prog_busy;
    wire is_wr = (CMD_CODE[7:5] == BSC_CMD_WR_BASE[7:5]);
    wire is_rd = (CMD_CODE[7:5] == BSC_CMD_RD_BASE[7:5]);
    wire is_ext = (CMD_CODE == BSC_CMD_EXT);
    wire is_prog = (CMD_CODE == BSC_CMD_PROG);
    wire is_br_nv = (CMD_CODE == BSC_CMD_BR_NV);
    wire is_br_host = (CMD_CODE == BSC_CMD_BR_HOST);
    wire is_t_nv = (CMD_CODE == BSC_CMD_T_NV);
    wire is_t_host = (CMD_CODE == BSC_CMD_T_HOST);
    wire is_corr = (CMD_CODE == BSC_CMD_CORR);
    wire is_temp = is_t_nv || is_t_host;
    wire is_host_cfg = is_br_host || is_t_host;
    wire is_nv_cfg = is_br_nv || is_t_nv || is_corr;

    // code low bits pick the word
    wire wr_en = cmd_take && is_wr;
    wire [4:0] wr_addr = CMD_CODE[4:0];
    wire [17:0] wr_data = {ext_q, CMD_DATA};

    wire [4:0] cfg_addr = is_t_nv ? BSC_ADDR_T_SETUP : BSC_ADDR_BR_SETUP;
    wire [4:0] fetch_addr = BSC_ADDR_COEF_BASE + step_q;
    wire in_fetch = (state_q == ST_FETCH);
    wire rd_nv = in_fetch || !is_rd;
    wire [4:0] rd_addr = in_fetch ? fetch_addr : (is_rd ? CMD_CODE[4:0] : cfg_addr);
    wire [4:0] fetch_idx = step_q - 5'd1;
    wire shape_s = c_q[BSC_C_SHAPE][BSC_SHAPE_BIT];

    bsc_coef_store u_store (
        .clk(CLK),
        .rst(RST),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .prog_start(cmd_take && is_prog),
        .prog_busy(prog_busy),
        .rd_nv(rd_nv),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // port drives; data outputs all come from registers
    assign CMD_READY = (state_q == ST_IDLE) && !prog_busy;
    assign MEAS_START = (state_q == ST_LAUNCH);
    assign MEAS_TEMP = temp_q;
    assign MEAS_CONFIG = cfg_q;
    assign RESULT_VALID = (state_q == ST_DONE);
    assign RESULT_DATA = result_q;
    assign RESULT_STATUS = {7'b000_0000, sat_q};
    assign PROG_BUSY = prog_busy;

    // sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (cmd_take && is_rd) begin
                    state_d = ST_READ;
                end else if (cmd_take && is_nv_cfg) begin
                    state_d = ST_CFG;
                end else if (cmd_take && is_host_cfg) begin
                    state_d = ST_LAUNCH;
                end
            end
            ST_CFG: state_d = ST_LAUNCH;
            ST_READ: state_d = ST_DONE;
            ST_LAUNCH: state_d = ST_WAIT;
            ST_WAIT: begin
                if (RAW_VALID) begin
                    state_d = corr_q ? ST_FETCH : ST_DONE;
                end
            end
            ST_FETCH: begin
                if (step_q == BSC_LAST_FETCH) begin
                    state_d = ST_CALC;
                end
            end
            ST_CALC: begin
                if (step_q == BSC_LAST_STEP) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    assign step_d = (state_d != state_q) ? 5'd0 : step_q + 5'd1;

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
            step_q <= '0;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
        end
    end

    // one shared multiply/add unit; the step table below picks operands
    logic signed [19:0] op_a, op_b;
    logic do_mul;
    logic signed [39:0] lim_lo, lim_hi;
    logic [2:0] dst;

    wire signed [19:0] dt = x20(w_q[BSC_W_DT]);
    wire signed [19:0] zv = x20(w_q[BSC_W_Z]);
    wire signed [19:0] z_abs = zv[19] ? -zv : zv;

    always_comb begin
        op_a = BSC_NIL;
        op_b = BSC_NIL;
        do_mul = 1'b0;
        lim_lo = BSC_S18_MIN;
        lim_hi = BSC_S18_MAX;
        dst = BSC_W_DT;
        case (step_q)
            5'd0: begin
                op_a = x20(traw_q);
                op_b = -x20(c_q[BSC_C_TREF]);
            end
            5'd1: begin
                op_a = x20(c_q[BSC_C_GAIN_DRIFT_QUADRATIC_COEF]);
                op_b = dt;
                do_mul = 1'b1;
                dst = BSC_W_TA;
            end
            5'd2: begin
                op_a = x20(w_q[BSC_W_TA]);
                op_b = x20(c_q[BSC_C_TCG]);
                dst = BSC_W_TA;
            end
            5'd3: begin
                op_a = dt;
                op_b = x20(w_q[BSC_W_TA]);
                do_mul = 1'b1;
                dst = BSC_W_TA;
            end
            5'd4: begin
                op_a = BSC_ONE;
                op_b = x20(w_q[BSC_W_TA]);
                dst = BSC_W_K1;
            end
            5'd5: begin
                op_a = x20(c_q[BSC_C_OFFSET_DRIFT_QUADRATIC_COEF]);
                op_b = dt;
                do_mul = 1'b1;
                dst = BSC_W_TB;
            end
            5'd6: begin
                op_a = x20(w_q[BSC_W_TB]);
                op_b = x20(c_q[BSC_C_TCO]);
                dst = BSC_W_TB;
            end
            5'd7: begin
                op_a = dt;
                op_b = x20(w_q[BSC_W_TB]);
                do_mul = 1'b1;
                dst = BSC_W_TB;
            end
            5'd8: begin
                op_a = x20(braw_q);
                op_b = x20(w_q[BSC_W_TB]);
                dst = BSC_W_TB;
            end
            5'd9: begin
                op_a = x20(c_q[BSC_C_OFFSET]);
                op_b = x20(w_q[BSC_W_TB]);
                dst = BSC_W_K2;
            end
            5'd10: begin
                op_a = x20(w_q[BSC_W_K1]);
                op_b = x20(w_q[BSC_W_K2]);
                do_mul = 1'b1;
                dst = BSC_W_P;
            end
            5'd11: begin
                op_a = x20(c_q[BSC_C_GAIN]);
                op_b = x20(w_q[BSC_W_P]);
                do_mul = 1'b1;
                dst = BSC_W_Z;
            end
            5'd12: begin
                op_a = zv;
                op_b = shape_s ? BSC_NIL : BSC_ONE;
                lim_lo = shape_s ? BSC_S18_MIN : BSC_ZERO;
                dst = BSC_W_Z;
            end
            5'd13: begin
                op_a = x20(c_q[BSC_C_LIN]);
                op_b = shape_s ? z_abs : zv;
                do_mul = 1'b1;
                dst = BSC_W_Q;
            end
            5'd14: begin
                op_a = x20(w_q[BSC_W_Q]);
                op_b = BSC_ONE;
                dst = BSC_W_Q;
            end
            5'd15: begin
                op_a = zv;
                op_b = x20(w_q[BSC_W_Q]);
                do_mul = 1'b1;
                lim_lo = shape_s ? BSC_S18_MIN : BSC_ZERO;
                lim_hi = shape_s ? BSC_S18_MAX : BSC_U16_MAX;
                dst = BSC_W_Q;
            end
            5'd16: begin
                op_a = x20(w_q[BSC_W_Q]);
                op_b = shape_s ? BSC_ONE : BSC_NIL;
                lim_lo = BSC_ZERO;
                lim_hi = BSC_U16_MAX;
                dst = BSC_W_Q;
            end
            default: begin
                dst = BSC_W_DT;
            end
        endcase
    end

    wire signed [39:0] prod = op_a * op_b;
    wire signed [39:0] prod_sh = prod >>> BSC_FRAC;
    wire signed [39:0] sum = {{20{op_a[19]}}, op_a} + {{20{op_b[19]}}, op_b};
    wire signed [39:0] alu_raw = do_mul ? prod_sh : sum;
    wire alu_hi = (alu_raw > lim_hi);
    wire alu_lo = (alu_raw < lim_lo);
    wire alu_sat = alu_hi || alu_lo;
    wire signed [39:0] alu_clamped = alu_hi ? lim_hi : (alu_lo ? lim_lo : alu_raw);
    wire [17:0] alu_res = alu_clamped[17:0];
    wire calc_last = (state_q == ST_CALC) && (step_q == BSC_LAST_STEP);

    // command side registers and setup word
    always_ff @(posedge CLK) begin
        if (RST) begin
            cfg_q <= '0;
            temp_q <= 1'b0;
            corr_q <= 1'b0;
            ext_q <= '0;
        end else begin
            if (cmd_take) begin
                temp_q <= is_temp;
                corr_q <= is_corr;
            end
            if (cmd_take && is_host_cfg) begin
                cfg_q <= CMD_DATA;
            end else if (state_q == ST_CFG) begin
                cfg_q <= rd_data[15:0];
            end
            // upper coefficient bits apply to the next write only
            if (cmd_take && is_ext) begin
                ext_q <= CMD_DATA[1:0];
            end else if (wr_en) begin
                ext_q <= '0;
            end
        end
    end

    // raw readings and result word
    always_ff @(posedge CLK) begin
        if (RST) begin
            traw_q <= '0;
            braw_q <= '0;
            result_q <= '0;
        end else if (state_q == ST_WAIT && RAW_VALID) begin
            if (temp_q) begin
                traw_q <= RAW_DATA;
            end else begin
                braw_q <= RAW_DATA;
            end
            result_q <= RAW_DATA;
        end else if (state_q == ST_READ) begin
            result_q <= rd_data;
        end else if (calc_last) begin
            result_q <= {2'b00, alu_res[15:0]};
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            sat_q <= 1'b0;
        end else if (cmd_take) begin
            sat_q <= 1'b0;
        end else if (state_q == ST_CALC) begin
            sat_q <= sat_q || alu_sat;
        end
    end

    // coefficient fetch and scratch slots; data trails the address by one
    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int i = 0; i < BSC_NCOEF; i++) begin
                c_q[i] <= '0;
            end
            for (int j = 0; j < 8; j++) begin
                w_q[j] <= '0;
            end
        end else if (in_fetch && step_q != 5'd0) begin
            c_q[fetch_idx[3:0]] <= rd_data;
        end else if (state_q == ST_CALC) begin
            w_q[dst] <= alu_res;
        end
    end

endmodule : bsc_top
